/* File: rtl/prot_override_defs.vh */
`ifndef PROT_OVERRIDE_DEFS_VH
`define PROT_OVERRIDE_DEFS_VH

// register byte offsets
`define OFS_COMMAND      8'h00
`define OFS_KEY_PARAM    8'h04
`define OFS_PFLASH_PARAM 8'h08
`define OFS_EEPROM_PARAM 8'h0c
`define OFS_PFLASH_PROT  8'h10
`define OFS_EEPROM_PROT  8'h14
`define OFS_PROT_STATUS  8'h18
`define OFS_FLASH_STATUS 8'h1c
`define OFS_CONFIG_KEY   8'h20

// command register fields
`define CMD_LAUNCH_BIT   0
`define CMD_SEL_LSB      4
`define CMD_IDX_LSB      8

// flash status fields
`define FLASH_STATUS_REG_DONE_BIT   7
`define FLASH_STATUS_REG_ACCESS_ERROR_FLAG_BIT 5

// protection status fields
`define PSTAT_OVRD_BIT   0

// constants
`define KEY_ERASED       16'hffff
`define IDX_KEY_ONLY     3'h1
`define IDX_PFLASH       3'h2
`define IDX_EEPROM       3'h3
`define SEL_NONE         2'h0
`define PFLASH_PROT_RST  8'h00
`define EEPROM_PROT_RST  8'h00
`define CONFIG_KEY_RST   16'hffff

// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

/* File: rtl/flash_protection_override_cmd.v */
// Summary of operation
// - key match saves both protection values then loads selected new ones
// - overridden protection values apply with no limit checks
// - successful override sets the override-active flag
// - key mismatch or all-ones key restores both and clears flag
// - erased stored key disables override until the config key register is written
// - launch with access error leaves both protection registers untouched
// - single save buffer overwritten on every override
// - restore discards direct writes made during override
// - restore loads saved values, never reset values
// - selection bit 1 chooses whether eeprom protection is loaded
// - access error when parameter index is not 001, 010 or 011
// - access error when command unavailable in current mode
// - access error on restore while override flag is clear
// - access error for selection 00 with index 010 or 011
// - access error for selection 00, index 001 and matching key
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "prot_override_defs.vh"

module flash_protection_override_cmd (
    // clock and reset
    input  wire        clk,
    input  wire        reset,
    // operating mode gate
    input  wire        command_allowed,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // protection values for the flash array logic
    output wire [7:0]  pflash_protection,
    output wire [7:0]  eeprom_protection,
    output wire        override_active
);

    // mode gate is from another domain
    reg        allowed_meta_reg;
    reg        allowed_sync_reg;

    reg [7:0]  aw_addr_reg;
    reg        aw_full_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;
    reg        w_full_reg;

    reg [2:0]  parameter_index_reg;
    reg [1:0]  update_select_reg;
    reg [15:0] key_param_reg;
    reg [7:0]  pflash_param_reg;
    reg [7:0]  eeprom_param_reg;
    reg [15:0] config_key_reg;

    reg [7:0]  pflash_protection_reg;
    reg [7:0]  eeprom_protection_reg;
    reg [7:0]  saved_pflash_reg;
    reg [7:0]  saved_eeprom_reg;
    reg        override_active_flag;
    reg        access_error_flag;

    wire       do_write;
    wire       launch;
    wire       idx_ok;
    wire       key_valid;
    wire       key_match;
    wire       restore_req;
    wire       launch_error;
    wire       grant;
    wire       restore;
    wire [31:0] cmd_word;
    wire [31:0] pstat_word;
    wire [31:0] flash_status_reg_word;

    wire       wr_command;
    wire       wr_pflash_prot;
    wire       wr_eeprom_prot;
    wire       wr_flash_status;

    wire       err_index;
    wire       err_mode;
    wire       err_no_saved;
    wire       err_sel_index;
    wire       err_sel_key;
    wire       load_pflash;
    wire       load_eeprom;

    wire [31:0] key_word;
    wire [31:0] pflash_param_word;
    wire [31:0] eeprom_param_word;
    wire [31:0] pflash_prot_word;
    wire [31:0] eeprom_prot_word;
    wire [31:0] config_word;

    reg  [31:0] rdata_next;
    reg  [1:0]  rresp_next;
    reg         wr_addr_mapped;

    always @(posedge clk) begin
        if (reset) begin
            allowed_meta_reg <= 1'b0;
            allowed_sync_reg <= 1'b0;
        end else begin
            allowed_meta_reg <= command_allowed;
            allowed_sync_reg <= allowed_meta_reg;
        end
    end

    // write channel capture, either order
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
    assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;

    // per-register write strobes
    assign wr_command      = do_write && (aw_addr_reg == `OFS_COMMAND);
    assign wr_pflash_prot  = do_write && (aw_addr_reg == `OFS_PFLASH_PROT);
    assign wr_eeprom_prot  = do_write && (aw_addr_reg == `OFS_EEPROM_PROT);
    assign wr_flash_status = do_write && (aw_addr_reg == `OFS_FLASH_STATUS);

    // unmapped offsets answer with an error response
    always @* begin
        wr_addr_mapped = 1'b0;
        case (aw_addr_reg)
            `OFS_COMMAND, `OFS_KEY_PARAM, `OFS_PFLASH_PARAM, `OFS_EEPROM_PARAM,
            `OFS_PFLASH_PROT, `OFS_EEPROM_PROT, `OFS_CONFIG_KEY,
            `OFS_PROT_STATUS, `OFS_FLASH_STATUS: begin
                wr_addr_mapped = 1'b1;
            end
            default: begin
                wr_addr_mapped = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            aw_addr_reg <= 8'h00;
            aw_full_reg <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            w_full_reg  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_addr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // command launch decode
    assign launch      = wr_command && w_strb_reg[0] && w_data_reg[`CMD_LAUNCH_BIT];
    assign key_valid   = (key_param_reg != `KEY_ERASED);
    assign key_match   = key_valid && (config_key_reg != `KEY_ERASED)
                         && (key_param_reg == config_key_reg);
    assign restore_req = !key_match;
    assign idx_ok      = (parameter_index_reg == `IDX_KEY_ONLY)
                         || (parameter_index_reg == `IDX_PFLASH)
                         || (parameter_index_reg == `IDX_EEPROM);

    // error causes; any one blocks the launch
    assign err_index     = !idx_ok;
    assign err_mode      = !allowed_sync_reg;
    assign err_no_saved  = restore_req && !override_active_flag;
    assign err_sel_index = (update_select_reg == `SEL_NONE)
                           && (parameter_index_reg != `IDX_KEY_ONLY);
    assign err_sel_key   = (update_select_reg == `SEL_NONE)
                           && (parameter_index_reg == `IDX_KEY_ONLY) && key_match;
    assign launch_error  = err_index || err_mode || err_no_saved || err_sel_index
                           || err_sel_key;
    assign grant       = launch && !launch_error && key_match;
    assign restore     = launch && !launch_error && restore_req;
    assign load_pflash = grant && update_select_reg[0];
    assign load_eeprom = grant && update_select_reg[1];

    // parameter and configuration registers
    always @(posedge clk) begin
        if (reset) begin
            parameter_index_reg <= 3'h0;
            update_select_reg   <= 2'h0;
            key_param_reg       <= 16'h0000;
            pflash_param_reg    <= 8'h00;
            eeprom_param_reg    <= 8'h00;
            config_key_reg      <= `CONFIG_KEY_RST;
        end else if (do_write) begin
            case (aw_addr_reg)
                `OFS_COMMAND: begin
                    if (w_strb_reg[0]) begin
                        update_select_reg <= w_data_reg[`CMD_SEL_LSB +: 2];
                    end
                    if (w_strb_reg[1]) begin
                        parameter_index_reg <= w_data_reg[`CMD_IDX_LSB +: 3];
                    end
                end
                `OFS_KEY_PARAM: begin
                    if (w_strb_reg[0]) key_param_reg[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) key_param_reg[15:8] <= w_data_reg[15:8];
                end
                `OFS_PFLASH_PARAM: begin
                    if (w_strb_reg[0]) pflash_param_reg <= w_data_reg[7:0];
                end
                `OFS_EEPROM_PARAM: begin
                    if (w_strb_reg[0]) eeprom_param_reg <= w_data_reg[7:0];
                end
                `OFS_CONFIG_KEY: begin
                    if (w_strb_reg[0]) config_key_reg[7:0]  <= w_data_reg[7:0];
                    if (w_strb_reg[1]) config_key_reg[15:8] <= w_data_reg[15:8];
                end
                default: begin
                end
            endcase
        end
    end

    // protection registers, save buffer and flags
    always @(posedge clk) begin
        if (reset) begin
            pflash_protection_reg <= `PFLASH_PROT_RST;
            eeprom_protection_reg <= `EEPROM_PROT_RST;
            saved_pflash_reg      <= `PFLASH_PROT_RST;
            saved_eeprom_reg      <= `EEPROM_PROT_RST;
            override_active_flag  <= 1'b0;
            access_error_flag     <= 1'b0;
        end else begin
            if (launch) begin
                access_error_flag <= launch_error;
            end else if (wr_flash_status && w_strb_reg[0] && w_data_reg[`FLASH_STATUS_REG_ACCESS_ERROR_FLAG_BIT]) begin
                access_error_flag <= 1'b0;
            end
            if (grant) begin
                saved_pflash_reg <= pflash_protection_reg;
                saved_eeprom_reg <= eeprom_protection_reg;
                if (load_pflash) begin
                    pflash_protection_reg <= pflash_param_reg;
                end
                if (load_eeprom) begin
                    eeprom_protection_reg <= eeprom_param_reg;
                end
                override_active_flag <= 1'b1;
            end else if (restore) begin
                pflash_protection_reg <= saved_pflash_reg;
                eeprom_protection_reg <= saved_eeprom_reg;
                override_active_flag  <= 1'b0;
            end else if (do_write && w_strb_reg[0] && !launch) begin
                // direct writes; the !launch term keeps an erroneous launch out, so it changes nothing
                if (wr_pflash_prot) begin
                    pflash_protection_reg <= w_data_reg[7:0];
                end
                if (wr_eeprom_prot) begin
                    eeprom_protection_reg <= w_data_reg[7:0];
                end
            end
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign cmd_word   = {21'h000000, parameter_index_reg, 2'h0, update_select_reg, 4'h0};
    assign pstat_word = {31'h00000000, override_active_flag};
    assign flash_status_reg_word = {24'h000000, 1'b1, 1'b0, access_error_flag, 5'h00};
    assign key_word          = {16'h0000, key_param_reg};
    assign pflash_param_word = {24'h000000, pflash_param_reg};
    assign eeprom_param_word = {24'h000000, eeprom_param_reg};
    assign pflash_prot_word  = {24'h000000, pflash_protection_reg};
    assign eeprom_prot_word  = {24'h000000, eeprom_protection_reg};
    assign config_word       = {16'h0000, config_key_reg};

    // read word chosen from the address before it is registered
    always @* begin
        rdata_next = 32'h00000000;
        rresp_next = `RESP_OKAY;
        case (s_axi_araddr)
            `OFS_COMMAND:      rdata_next = cmd_word;
            `OFS_KEY_PARAM:    rdata_next = key_word;
            `OFS_PFLASH_PARAM: rdata_next = pflash_param_word;
            `OFS_EEPROM_PARAM: rdata_next = eeprom_param_word;
            `OFS_PFLASH_PROT:  rdata_next = pflash_prot_word;
            `OFS_EEPROM_PROT:  rdata_next = eeprom_prot_word;
            `OFS_PROT_STATUS:  rdata_next = pstat_word;
            `OFS_FLASH_STATUS: rdata_next = flash_status_reg_word;
            `OFS_CONFIG_KEY:   rdata_next = config_word;
            default: begin
                rdata_next = 32'h00000000;
                rresp_next = `RESP_SLVERR;
            end
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_next;
            s_axi_rresp  <= rresp_next;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign pflash_protection = pflash_protection_reg;
    assign eeprom_protection = eeprom_protection_reg;
    assign override_active   = override_active_flag;

endmodule // flash_protection_override_cmd

/* File: testbench/flash_protection_override_cmd_checker.sv */
`timescale 1ns/1ps
module prot_ovr_checker (
    // clock and reset
    input wire        clk,
    input wire        reset,
    // bus handshakes
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // protection outputs
    input wire [7:0]  pflash_protection,
    input wire [7:0]  eeprom_protection,
    input wire        override_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // a launch lands around the write response
    sequence s_resp_near;
        s_axi_bvalid || $past(s_axi_bvalid);
    endsequence
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_wr_lat;
        s_wr_taken |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_ready_gate;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_pflash_cause;
        $changed(pflash_protection) |-> s_resp_near;
    endproperty
    property p_eeprom_cause;
        $changed(eeprom_protection) |-> s_resp_near;
    endproperty
    property p_flag_cause;
        $changed(override_active) |-> s_resp_near;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    a_ready_gate: assert property (p_ready_gate) else $error("ready during response");
    a_pflash_cause: assert property (p_pflash_cause) else $error("pflash moved alone");
    a_eeprom_cause: assert property (p_eeprom_cause) else $error("eeprom moved alone");
    a_flag_cause: assert property (p_flag_cause) else $error("flag moved alone");
endmodule // prot_ovr_checker

bind flash_protection_override_cmd prot_ovr_checker i_prot_ovr_checker (.clk, .reset,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .pflash_protection, .eeprom_protection, .override_active);

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`include "prot_override_defs.vh"
module tb;
    reg         clk, reset, command_allowed;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata, rd_data;
    reg  [3:0]  s_axi_wstrb;
    reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0]  pflash_protection, eeprom_protection;
    wire        override_active;
    reg  [1:0]  resp;
    reg  [29:0] tab;
    integer     n_errors, checks_done, i;
    flash_protection_override_cmd i_flash_protection_override_cmd (.clk, .reset,
        .command_allowed, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pflash_protection, .eeprom_protection, .override_active);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task results;
        begin
            $display("errors %0d checks %0d", n_errors, checks_done);
            if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        integer n;
        begin
            n = 0;
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge clk);
                n = n + 1;
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (!s_axi_bvalid && n < 40);
            if (!s_axi_bvalid) n_errors = n_errors + 1;
            if (!s_axi_bvalid) results;
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd(input [7:0] a);
        integer n;
        begin
            n = 0;
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(posedge clk);
                n = n + 1;
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (!s_axi_rvalid && n < 40);
            if (!s_axi_rvalid) n_errors = n_errors + 1;
            if (!s_axi_rvalid) results;
            rd_data = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            @(posedge clk);
        end
    endtask
    // selection and index stored first, launch uses the stored pair
    task lau(input [1:0] s, input [2:0] x);
        begin
            wr(`OFS_COMMAND, {21'h0, x, 2'h0, s, 4'h0});
            wr(`OFS_COMMAND, {21'h0, x, 2'h0, s, 4'h1});
        end
    endtask
    task acc(input e);
        begin
            rd(`OFS_FLASH_STATUS);
            chk({31'h0, rd_data[`FLASH_STATUS_REG_ACCESS_ERROR_FLAG_BIT]}, {31'h0, e});
        end
    endtask
    task prt(input [7:0] p, input [7:0] q, input f);
        begin
            chk({24'h0, pflash_protection}, {24'h0, p});
            chk({24'h0, eeprom_protection}, {24'h0, q});
            chk({31'h0, override_active}, {31'h0, f});
        end
    endtask
    initial begin
        {reset, command_allowed, s_axi_wstrb} = 6'h3f;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        tab = {5'h18, 5'h1c, 5'h1f, 5'h02, 5'h03, 5'h01};
        n_errors = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(`OFS_CONFIG_KEY);
        chk(rd_data, 32'hffff);
        wr(`OFS_KEY_PARAM, 32'h1234);
        lau(2'h3, 3'h1);
        acc(1'b1);
        prt(8'h00, 8'h00, 1'b0);
        wr(`OFS_CONFIG_KEY, 32'h1234);
        wr(`OFS_PFLASH_PROT, 32'h11);
        wr(`OFS_EEPROM_PROT, 32'h22);
        wr(`OFS_PFLASH_PARAM, 32'ha5);
        wr(`OFS_EEPROM_PARAM, 32'h5a);
        lau(2'h1, 3'h3);
        acc(1'b0);
        prt(8'ha5, 8'h22, 1'b1);
        rd(`OFS_PROT_STATUS);
        chk(rd_data, 32'h1);
        lau(2'h2, 3'h3);
        prt(8'ha5, 8'h5a, 1'b1);
        wr(`OFS_PFLASH_PROT, 32'h77);
        wr(`OFS_KEY_PARAM, 32'h4321);
        lau(2'h0, 3'h1);
        acc(1'b0);
        prt(8'ha5, 8'h22, 1'b0);
        wr(`OFS_KEY_PARAM, 32'h1234);
        wr(`OFS_PFLASH_PARAM, 32'h00);
        wr(`OFS_EEPROM_PARAM, 32'hff);
        lau(2'h3, 3'h3);
        prt(8'h00, 8'hff, 1'b1);
        wr(`OFS_PFLASH_PARAM, 32'h33);
        wr(`OFS_EEPROM_PARAM, 32'h44);
        for (i = 0; i < 6; i = i + 1) begin
            wr(`OFS_FLASH_STATUS, 32'h20);
            acc(1'b0);
            lau(tab[i*5+3 +: 2], tab[i*5 +: 3]);
            acc(1'b1);
            prt(8'h00, 8'hff, 1'b1);
        end
        command_allowed <= 1'b0;
        repeat (3) @(posedge clk);
        wr(`OFS_FLASH_STATUS, 32'h20);
        acc(1'b0);
        lau(2'h3, 3'h3);
        acc(1'b1);
        prt(8'h00, 8'hff, 1'b1);
        command_allowed <= 1'b1;
        repeat (3) @(posedge clk);
        wr(`OFS_KEY_PARAM, 32'hffff);
        lau(2'h0, 3'h1);
        acc(1'b0);
        prt(8'ha5, 8'h22, 1'b0);
        rd(8'h40);
        chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
        wr(8'h40, 32'h0);
        chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
        results;
    end
endmodule // tb
